// ===== rtl/sefq_pkg.sv
// constants for the status query block: command codes, flag layout,
// register map and timing counts.
// assumes a single 25 MHz clock domain shared with the command processor.
`default_nettype none

package sefq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TRIG_TIMEOUT_S = 5;
  localparam int unsigned TRIG_TIMEOUT_CYC = TRIG_TIMEOUT_S * CLK_HZ;

  ////////////////////////////////////////////////////////////////////////
  // command framing
  localparam logic [7:0] CMD_STATUS = 8'h43;
  localparam logic [7:0] CMD_BITRATE = 8'h44;
  localparam logic [7:0] CMD_PARAM_SET = 8'h47;
  localparam logic [7:0] LEN_STATUS = 8'h02;
  localparam logic [7:0] LEN_BITRATE = 8'h04;
  localparam logic [7:0] LEN_PARAM_SET = 8'h01;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_REPLY = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // first status byte bit positions
  localparam int unsigned B0_TRIG_LOST = 0;
  localparam int unsigned B0_RESET_SEEN = 1;
  localparam int unsigned B0_UNLOCKED = 2;
  localparam int unsigned B0_RESERVED = 3;
  localparam int unsigned B0_UNKNOWN_CODE = 4;
  localparam int unsigned B0_ACCESS_DENIED = 5;
  localparam int unsigned B0_LEN_MISMATCH = 6;
  localparam int unsigned B0_PARAM_ERR = 7;
  // second status byte bit positions
  localparam int unsigned B1_LOGIC_ERR = 0;

  ////////////////////////////////////////////////////////////////////////
  // apb register map, byte addresses
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;

  // interrupt bit positions
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_UNKNOWN = 0;
  localparam int unsigned IRQ_DENIED = 1;
  localparam int unsigned IRQ_LEN = 2;
  localparam int unsigned IRQ_TRIG_LOST = 3;
  localparam int unsigned IRQ_QUERY = 4;
  localparam logic [4:0] IRQ_EN_RST = 5'h00;

endpackage

`default_nettype wire

// ===== rtl/sefq_trig_watch.sv
// watchdog on the external line trigger pin: raises a level when no
// rising edge has been seen for the configured number of cycles.
// assumes the pin is asynchronous to pclk; it is synchronised here.
`default_nettype none

module sefq_trig_watch #(
  parameter int unsigned TIMEOUT_CYC = sefq_pkg::TRIG_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic external_line_trigger,
  output logic lost,
  output logic lost_rise
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

  generate
    if (TIMEOUT_CYC < 1)
    begin : g_bad_timeout
      $error("timeout must be at least one cycle");
    end
  endgenerate

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [CW-1:0] cnt_r;
  logic lost_r;
  logic edge_seen;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser, then an edge detector on the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= external_line_trigger;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign edge_seen = sync2_r && !prev_r;

  // counter saturates so the flag stays up until the next edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
    end
    else if (edge_seen)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r != CW'(TIMEOUT_CYC))
    begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lost_r <= 1'b0;
    end
    else
    begin
      lost_r <= !edge_seen && (cnt_r == CW'(TIMEOUT_CYC));
    end
  end

  assign lost = lost_r;
  assign lost_rise = !lost_r && !edge_seen && (cnt_r == CW'(TIMEOUT_CYC));

endmodule

`default_nettype wire

// ===== rtl/sefq_status_query.sv
// status/error flag query for the serial command processor, with an apb
// register view of the same flags and one level interrupt.
// assumes command strobes, access-denied and error levels come from logic
// on pclk; only the trigger pin is asynchronous.
//
// Behaviour
// [R1] status query 0x43 read, length 2, two-byte reply
// [R2] bit one means condition present, zero absent
// [R3] fixed map: trigger lost, unlocked, reserved, logic error
// [R4] bit 1 marks that a reset happened
// [R5] bit 4 marks unknown command code
// [R6] bit 5 marks command refused, access denied
// [R7] bit 6 marks length field mismatch
// [R8] bit 7 parameter error reserved, reads zero
// [R9] event flags latched until reported by query
`default_nettype none

module sefq_status_query #(
  parameter int unsigned TRIG_TIMEOUT_CYC = sefq_pkg::TRIG_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sefq_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded command from the command processor
  input wire logic cmd_valid,
  input wire logic [7:0] command_code,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_len,
  input wire logic access_denied,
  // condition levels
  input wire logic unlocked,
  input wire logic logic_error,
  input wire logic external_line_trigger,
  // reply toward the serial transmitter
  output logic rsp_valid,
  output logic [7:0] rsp_code,
  output logic rsp_read,
  output logic [7:0] rsp_len,
  output logic [7:0] rsp_byte0,
  output logic [7:0] rsp_byte1,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // defined length lookup: {known, length}
  function automatic logic [8:0] len_lookup(input logic [7:0] code);
    logic [8:0] r;
    r = 9'h000;
    case (code)
      sefq_pkg::CMD_STATUS: r = {1'b1, sefq_pkg::LEN_STATUS};
      sefq_pkg::CMD_BITRATE: r = {1'b1, sefq_pkg::LEN_BITRATE};
      sefq_pkg::CMD_PARAM_SET: r = {1'b1, sefq_pkg::LEN_PARAM_SET};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  logic [8:0] lk;
  logic code_known;
  logic len_bad;
  logic is_query;
  logic evt_unknown;
  logic evt_len;
  logic evt_denied;
  logic trig_lost;
  logic trig_lost_rise;

  logic unknown_r;
  logic denied_r;
  logic len_r;
  logic reset_seen_r;
  logic [7:0] byte0;
  logic [7:0] byte1;

  ////////////////////////////////////////////////////////////////////////
  // trigger watchdog
  sefq_trig_watch #(
    .TIMEOUT_CYC(TRIG_TIMEOUT_CYC)
  ) u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .external_line_trigger(external_line_trigger),
    .lost(trig_lost),
    .lost_rise(trig_lost_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // command classification
  assign lk = len_lookup(command_code);
  assign code_known = lk[8];
  assign len_bad = code_known && (cmd_len != lk[7:0]);
  // [R1] query recognition
  assign is_query = cmd_valid && (command_code == sefq_pkg::CMD_STATUS)
    && (cmd_read == sefq_pkg::RW_READ) && !len_bad;
  // [R5] unknown code
  assign evt_unknown = cmd_valid && !code_known;
  // [R7] length mismatch
  assign evt_len = cmd_valid && len_bad;
  // [R6] refused access; a write to the read-only query is refused too
  assign evt_denied = access_denied || (cmd_valid && !len_bad
    && (command_code == sefq_pkg::CMD_STATUS) && (cmd_read != sefq_pkg::RW_READ));

  ////////////////////////////////////////////////////////////////////////
  // sticky event flags; a set in the reporting cycle survives the clear
  // [R9] latch until reported
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unknown_r <= 1'b0;
      denied_r <= 1'b0;
      len_r <= 1'b0;
    end
    else
    begin
      unknown_r <= evt_unknown || (unknown_r && !is_query);
      denied_r <= evt_denied || (denied_r && !is_query);
      len_r <= evt_len || (len_r && !is_query);
    end
  end

  // [R4] reset marker set by reset itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_seen_r <= 1'b1;
    end
    else if (is_query)
    begin
      reset_seen_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status bytes; reserved positions stay zero
  // [R2] one means present
  // [R3] byte map
  // [R8] parameter error reserved
  always_comb
  begin
    byte0 = 8'h00;
    byte1 = 8'h00;
    byte0[sefq_pkg::B0_TRIG_LOST] = trig_lost;
    byte0[sefq_pkg::B0_RESET_SEEN] = reset_seen_r;
    byte0[sefq_pkg::B0_UNLOCKED] = unlocked;
    byte0[sefq_pkg::B0_UNKNOWN_CODE] = unknown_r;
    byte0[sefq_pkg::B0_ACCESS_DENIED] = denied_r;
    byte0[sefq_pkg::B0_LEN_MISMATCH] = len_r;
    byte1[sefq_pkg::B1_LOGIC_ERR] = logic_error;
  end

  ////////////////////////////////////////////////////////////////////////
  // reply: one-cycle strobe, header and data held until the next reply
  // [R1] reply framing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsp_valid <= 1'b0;
      rsp_code <= 8'h00;
      rsp_read <= 1'b0;
      rsp_len <= 8'h00;
      rsp_byte0 <= 8'h00;
      rsp_byte1 <= 8'h00;
    end
    else
    begin
      rsp_valid <= is_query;
      if (is_query)
      begin
        rsp_code <= sefq_pkg::CMD_STATUS;
        rsp_read <= sefq_pkg::RW_REPLY;
        rsp_len <= sefq_pkg::LEN_STATUS;
        rsp_byte0 <= byte0;
        rsp_byte1 <= byte1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state so read data can come from a flop
  logic apb_access;
  logic wr_fire;
  logic pready_r;
  logic [31:0] rdata_nxt;
  logic addr_ok;
  logic [sefq_pkg::IRQ_W-1:0] irq_en_r;
  logic [sefq_pkg::IRQ_W-1:0] irq_stat_r;
  logic [sefq_pkg::IRQ_W-1:0] irq_evt;
  logic [sefq_pkg::IRQ_W-1:0] irq_clr;

  assign apb_access = psel && penable;
  assign wr_fire = apb_access && pready_r && pwrite;

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      sefq_pkg::OFS_STATUS: rdata_nxt = {16'h0000, byte1, byte0};
      sefq_pkg::OFS_IRQ_STAT: rdata_nxt = {27'h0, irq_stat_r};
      sefq_pkg::OFS_IRQ_EN: rdata_nxt = {27'h0, irq_en_r};
      sefq_pkg::OFS_IRQ_CLR: rdata_nxt = 32'h0000_0000;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_access && !pready_r)
    begin
      pready_r <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= !addr_ok;
    end
    else
    begin
      pready_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  assign pready = pready_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en_r <= sefq_pkg::IRQ_EN_RST;
    end
    else if (wr_fire && paddr == sefq_pkg::OFS_IRQ_EN)
    begin
      irq_en_r <= pwdata[sefq_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: write one to clear, a same-cycle event wins
  always_comb
  begin
    irq_evt = '0;
    irq_evt[sefq_pkg::IRQ_UNKNOWN] = evt_unknown;
    irq_evt[sefq_pkg::IRQ_DENIED] = evt_denied;
    irq_evt[sefq_pkg::IRQ_LEN] = evt_len;
    irq_evt[sefq_pkg::IRQ_TRIG_LOST] = trig_lost_rise;
    irq_evt[sefq_pkg::IRQ_QUERY] = is_query;
  end

  assign irq_clr = (wr_fire && paddr == sefq_pkg::OFS_IRQ_CLR)
    ? pwdata[sefq_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_r <= '0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end
  end

  // one cycle behind the status, kept in a flop for a clean output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_query_answer: assert property ( // [R1]
    is_query |=> rsp_valid && rsp_code == 8'h43 && rsp_len == 8'h02 && !rsp_read)
    else $error("status query not answered with proper header");

  a_reply_cause: assert property ( // [R1]
    rsp_valid |-> $past(cmd_valid) && $past(command_code) == 8'h43 && $past(cmd_read))
    else $error("reply without a status query");

  a_reserved_zero: assert property ( // [R8]
    rsp_valid |-> !rsp_byte0[3] && !rsp_byte0[7] && rsp_byte1[7:1] == 7'h00)
    else $error("reserved status bit set");

  a_level_bits: assert property ( // [R3]
    rsp_valid |-> rsp_byte0[2] == $past(unlocked) && rsp_byte1[0] == $past(logic_error))
    else $error("level condition misreported");

  a_trig_bit: assert property ( // [R3]
    rsp_valid |-> rsp_byte0[0] == $past(trig_lost))
    else $error("trigger lost misreported");

  a_write_refused: assert property ( // [R6]
    cmd_valid && command_code == 8'h43 && !cmd_read && cmd_len == 8'h02
    |=> denied_r && !rsp_valid)
    else $error("write to status query not refused");

  a_reset_flag: assert property ( // [R4]
    rsp_valid && $past(reset_seen_r) |-> rsp_byte0[1] ##1 !reset_seen_r [*2])
    else $error("reset marker not reported or not cleared");

  a_unknown_set: assert property ( // [R5]
    cmd_valid && !code_known |=> unknown_r ##0 !rsp_valid)
    else $error("unknown code not flagged");

  a_denied_set: assert property ( // [R6]
    access_denied |=> denied_r)
    else $error("access denial not flagged");

  a_len_set: assert property ( // [R7]
    cmd_valid && code_known && cmd_len != lk[7:0] |=> len_r && !rsp_valid)
    else $error("length mismatch not flagged");

  a_flag_hold: assert property ( // [R9]
    unknown_r && !is_query |=> unknown_r)
    else $error("event flag lost before report");

  a_flag_report: assert property ( // [R2]
    is_query && unknown_r |=> rsp_valid && rsp_byte0[4])
    else $error("latched flag not reported as one");

endmodule

`default_nettype wire

// ===== tb/sefq_host_model.sv
// host on the far side of the serial command link: issues decoded
// commands and collects replies.
// assumes each task is entered right after a rising pclk edge.
`default_nettype none

module sefq_host_model (
  input wire logic pclk,
  output logic cmd_valid,
  output logic [7:0] command_code,
  output logic cmd_read,
  output logic [7:0] cmd_len,
  output logic access_denied,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_code,
  input wire logic rsp_read,
  input wire logic [7:0] rsp_len,
  input wire logic [7:0] rsp_byte0,
  input wire logic [7:0] rsp_byte1
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    cmd_valid = 1'b0;
    command_code = 8'h00;
    cmd_read = 1'b0;
    cmd_len = 8'h00;
    access_denied = 1'b0;
  end

  // one-cycle command, reply looked for in the next cycle
  task automatic send(input logic [7:0] code, input logic rd, input logic [7:0] len,
    input logic den, output logic got, output logic [31:0] hdr, output logic [15:0] dat);
    begin
      cmd_valid <= 1'b1;
      command_code <= code;
      cmd_read <= rd;
      cmd_len <= len;
      access_denied <= den;
      @(posedge pclk);
      // released fields show junk, not the last command
      cmd_valid <= 1'b0;
      access_denied <= 1'b0;
      command_code <= ~code;
      cmd_len <= ~len;
      cmd_read <= ~rd;
      // reply strobe still stands at this edge, taken before it drops
      @(posedge pclk);
      got = rsp_valid;
      hdr = {15'h0, rsp_read, rsp_code, rsp_len};
      dat = {rsp_byte1, rsp_byte0};
    end
  endtask

  task automatic query(output logic got, output logic [31:0] hdr, output logic [15:0] dat);
    send(sefq_pkg::CMD_STATUS, sefq_pkg::RW_READ, sefq_pkg::LEN_STATUS, 1'b0, got, hdr, dat);
  endtask
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the status query block: command rows, apb
// register view, interrupt, trigger watchdog and a second reset.
// assumes the host model and the design share pclk.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // short watchdog so the trigger-lost case fits the run
  localparam int unsigned TMO = 20;
  typedef struct packed {
    logic [7:0] code; logic rd; logic [7:0] len; logic den;
    logic unl; logic lerr; logic rep; logic [15:0] exp;
  } sefq_row_t;

  logic pclk, presetn, psel, penable, pwrite, irq, pready, pslverr, rerr, got;
  logic [sefq_pkg::APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rq, hdr;
  logic cmd_valid, cmd_read, access_denied, unlocked, logic_error, trig_run;
  logic trig = 1'b0;
  logic [7:0] command_code, cmd_len, rsp_code, rsp_len, rsp_byte0, rsp_byte1;
  logic rsp_valid, rsp_read;
  logic [15:0] dat;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  sefq_row_t rows [8] = '{
    '{8'h43, 1'b1, 8'h02, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000},
    '{8'h43, 1'b1, 8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040},
    '{8'h43, 1'b0, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0020},
    '{8'h55, 1'b1, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0010},
    '{8'h44, 1'b0, 8'h04, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0020},
    '{8'h44, 1'b0, 8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040},
    '{8'h47, 1'b0, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0004},
    '{8'h47, 1'b0, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100}};

  sefq_status_query #(.TRIG_TIMEOUT_CYC(TMO)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .command_code(command_code), .cmd_read(cmd_read), .cmd_len(cmd_len),
    .access_denied(access_denied), .unlocked(unlocked), .logic_error(logic_error),
    .external_line_trigger(trig), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
    .rsp_read(rsp_read), .rsp_len(rsp_len), .rsp_byte0(rsp_byte0),
    .rsp_byte1(rsp_byte1), .irq(irq));

  sefq_host_model host (.pclk(pclk), .cmd_valid(cmd_valid), .command_code(command_code),
    .cmd_read(cmd_read), .cmd_len(cmd_len), .access_denied(access_denied),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_read(rsp_read), .rsp_len(rsp_len),
    .rsp_byte0(rsp_byte0), .rsp_byte1(rsp_byte1));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // trigger edge every 8 cycles keeps the watchdog quiet
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (trig_run && cyc % 4 == 0)
      trig <= ~trig;
    if (cyc == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        err_total++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      if (n == 20)
        err_total++;
      rq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task q_chk(input logic [15:0] e);
    begin
      host.query(got, hdr, dat);
      chk("reply", 32'h1, {31'h0, got});
      chk("header", 32'h00004302, hdr);
      chk("flags", {16'h0, e}, {16'h0, dat});
    end
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    unlocked = 1'b0;
    logic_error = 1'b0;
    trig_run = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, sefq_pkg::OFS_IRQ_EN, 32'h0);
    chk("irq_en reset", 32'h0, rq);
    q_chk(16'h0002);
    $display("reset test done");
    foreach (rows[i])
    begin
      unlocked <= rows[i].unl;
      logic_error <= rows[i].lerr;
      host.send(rows[i].code, rows[i].rd, rows[i].len, rows[i].den, got, hdr, dat);
      chk("reply seen", {31'h0, rows[i].rep}, {31'h0, got});
      q_chk(rows[i].exp);
      $display("row %0d done", i);
    end
    host.send(8'h55, 1'b1, 8'h02, 1'b0, got, hdr, dat);
    repeat (2)
    begin
      apb(1'b0, sefq_pkg::OFS_STATUS, 32'h0);
      chk("status held", 32'h00000110, rq);
    end
    logic_error <= 1'b0;
    apb(1'b1, sefq_pkg::OFS_STATUS, 32'hffffffff);
    q_chk(16'h0010);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    $display("status test done");
    apb(1'b1, sefq_pkg::OFS_IRQ_CLR, 32'h0000001f);
    apb(1'b1, sefq_pkg::OFS_IRQ_EN, 32'h00000001);
    host.send(8'h55, 1'b1, 8'h02, 1'b0, got, hdr, dat);
    repeat (3) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, sefq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h00000001, rq);
    apb(1'b1, sefq_pkg::OFS_IRQ_EN, 32'h0);
    @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, sefq_pkg::OFS_IRQ_EN, 32'h00000001);
    @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, sefq_pkg::OFS_IRQ_CLR, 32'h00000001);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("irq test done");
    q_chk(16'h0010);
    trig_run <= 1'b0;
    repeat (TMO + 20) @(posedge pclk);
    q_chk(16'h0001);
    apb(1'b0, sefq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq_stat trig", 32'h00000018, rq);
    trig_run <= 1'b1;
    repeat (20) @(posedge pclk);
    q_chk(16'h0000);
    $display("trigger test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    q_chk(16'h0002);
    $display("second reset test done");
    wrap_up();
  end
endmodule

`default_nettype wire
